// File: spc_peer_model.sv
`default_nettype none
module spc_peer_model (
    input wire logic [3:0] out,
    input wire logic [3:0] oe_n,
    input wire logic [5:0] lvl,
    output logic [3:0] pin,
    output logic rx_data_pin,
    output logic ext_clock_in_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // the far device only drives a shared pin the block has released
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin[i] = oe_n[i] ? lvl[i] : out[i];
        end
    end
    assign rx_data_pin = lvl[4];
    assign ext_clock_in_pin = lvl[5];
endmodule : spc_peer_model
`default_nettype wire

// File: spc_pin_control.sv
`default_nettype none
module spc_pin_control
    import spc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic srg_clock,
    input wire logic srg_fsync,
    input wire logic tx_copy_fsync,
    input wire logic tx_data_bit,
    input wire logic tx_data_drive,
    output logic tx_data_pin_out,
    output logic tx_data_pin_oe_n,
    input wire logic tx_fsync_pin_in,
    output logic tx_fsync_pin_out,
    output logic tx_fsync_pin_oe_n,
    input wire logic tx_clock_pin_in,
    output logic tx_clock_pin_out,
    output logic tx_clock_pin_oe_n,
    input wire logic rx_fsync_pin_in,
    output logic rx_fsync_pin_out,
    output logic rx_fsync_pin_oe_n,
    input wire logic rx_clock_pin_in,
    output logic rx_clock_pin_out,
    output logic rx_clock_pin_oe_n,
    input wire logic rx_data_pin,
    input wire logic ext_clock_in_pin,
    output logic tx_clock_int,
    output logic rx_clock_int,
    output logic tx_fsync_int,
    output logic rx_fsync_int,
    output logic rx_data_bit,
    output logic spi_master
);
    logic [DATA_W-1:0] pin_control;
    logic [DATA_W-1:0] serial_ctrl;
    logic [4:0] pins_sync;
    logic rx_sample_link;

    // pin inputs enter through two flops before any ref_clk logic reads them
    spc_sync #(.WIDTH(5)) u_pin_sync (
        .clk(ref_clk),
        .reset(reset),
        .d({ext_clock_in_pin, rx_data_pin, rx_clock_pin_in, rx_fsync_pin_in, tx_clock_pin_in}),
        .q(pins_sync)
    );

    wire logic tx_clock_in_s = pins_sync[0];
    wire logic rx_fsync_in_s = pins_sync[1];
    wire logic rx_clock_in_s = pins_sync[2];
    wire logic rx_data_in_s = pins_sync[3];
    wire logic ext_clock_in_s = pins_sync[4];

    logic tx_fsync_in_s;
    spc_sync #(.WIDTH(1)) u_fsx_sync (
        .clk(ref_clk),
        .reset(reset),
        .d(tx_fsync_pin_in),
        .q(tx_fsync_in_s)
    );

    // serial data capture runs on the link clock, the bit crosses back as a level
    spc_rx_sample u_rx_sample (
        .link_clk(link_clk),
        .reset(reset),
        .rx_data_pin(rx_data_pin),
        .rx_clock_polarity(pin_control[RX_CLOCK_POL_BIT]),
        .rx_sample(rx_sample_link)
    );

    logic rx_sample_s;
    spc_sync #(.WIDTH(1)) u_rxd_sync (
        .clk(ref_clk),
        .reset(reset),
        .d(rx_sample_link),
        .q(rx_sample_s)
    );

    // register fields
    wire logic tx_gpio_enable = pin_control[TX_GPIO_ENABLE_BIT];
    wire logic rx_gpio_enable = pin_control[RX_GPIO_ENABLE_BIT];
    wire logic tx_fsync_source = pin_control[TX_FSYNC_SOURCE_BIT];
    wire logic rx_fsync_source = pin_control[RX_FSYNC_SOURCE_BIT];
    wire logic tx_clock_source = pin_control[TX_CLOCK_SOURCE_BIT];
    wire logic rx_clock_source = pin_control[RX_CLOCK_SOURCE_BIT];
    wire logic tx_data_pin_level = pin_control[TX_DATA_LEVEL_BIT];
    wire logic tx_fsync_polarity = pin_control[TX_FSYNC_POL_BIT];
    wire logic rx_fsync_polarity = pin_control[RX_FSYNC_POL_BIT];
    wire logic tx_clock_polarity = pin_control[TX_CLOCK_POL_BIT];
    wire logic rx_clock_polarity = pin_control[RX_CLOCK_POL_BIT];
    wire logic rx_section_reset_n = serial_ctrl[RX_SECTION_RESET_N_BIT];
    wire logic tx_section_reset_n = serial_ctrl[TX_SECTION_RESET_N_BIT];
    wire logic digital_loopback = serial_ctrl[DIGITAL_LOOPBACK_BIT];
    wire logic [1:0] clock_stop_mode = serial_ctrl[CLOCK_STOP_MODE_HI:CLOCK_STOP_MODE_LO];
    wire logic clock_sync_mode = serial_ctrl[CLOCK_SYNC_MODE_BIT];
    wire logic tx_fsync_gen_select = serial_ctrl[TX_FSYNC_GEN_SELECT_BIT];

    // exact compare: unmapped addresses write nowhere and read back zero
    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] target
    );
        return a == target;
    endfunction : addr_hit

    // frame sync polarity is applied once at the pin; the core always sees active-high frame syncs
    function automatic logic pol_level(input logic level, input logic pol);
        return level ^ pol;
    endfunction : pol_level

    // in gpio mode the serial core must see a quiet line, never a toggling pin
    function automatic logic serial_only(input logic gpio, input logic level);
        return gpio ? 1'b0 : level;
    endfunction : serial_only

    // in gpio mode a two-way pin shows its polarity bit as the driven level
    function automatic logic gpio_level(input logic gpio, input logic pol, input logic level);
        return gpio ? pol : level;
    endfunction : gpio_level

    function automatic logic oe_n_of(input logic drive);
        return ~drive;
    endfunction : oe_n_of

    // modes
    wire logic tx_gpio_mode = tx_gpio_enable & ~tx_section_reset_n;
    wire logic rx_gpio_mode = rx_gpio_enable & ~rx_section_reset_n;
    wire logic spi_mode = |clock_stop_mode;

    // register bus decode
    wire logic hit_pin = addr_hit(reg_addr, PIN_CONTROL_ADDR);
    wire logic hit_ctrl = addr_hit(reg_addr, SERIAL_CTRL_ADDR);
    wire logic wr_pin = reg_wr & hit_pin;
    wire logic wr_ctrl = reg_wr & hit_ctrl;

    // only the writable fields ever store; reserved and status bits stay zero
    wire logic [DATA_W-1:0] next_pin_control = reg_wdata & PIN_CONTROL_WMASK;
    wire logic [DATA_W-1:0] next_serial_ctrl = reg_wdata & SERIAL_CTRL_WMASK;

    // status bits show the synchronised pin levels
    wire logic [DATA_W-1:0] pin_status =
        ({{(DATA_W-1){1'b0}}, ext_clock_in_s} << EXT_CLOCK_LEVEL_BIT)
        | ({{(DATA_W-1){1'b0}}, rx_data_in_s} << RX_DATA_LEVEL_BIT);
    wire logic [DATA_W-1:0] pin_readback = pin_control | pin_status;

    wire logic [DATA_W-1:0] next_reg_rdata;
    assign next_reg_rdata = !reg_rd ? reg_rdata
        : hit_pin ? pin_readback
        : hit_ctrl ? serial_ctrl
        : '0;

    // reset values keep every clock and frame sync pin released until software picks a direction
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_control <= PIN_CONTROL_RESET;
        end else if (wr_pin) begin
            pin_control <= next_pin_control;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            serial_ctrl <= SERIAL_CTRL_RESET;
        end else if (wr_ctrl) begin
            serial_ctrl <= next_serial_ctrl;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // transmit data pin
    wire logic next_tx_data_pin_out = tx_gpio_mode ? tx_data_pin_level : tx_data_bit;
    wire logic next_tx_data_pin_oe_n = tx_gpio_mode ? 1'b0 : oe_n_of(tx_data_drive);

    // transmit frame sync: internal pulse is active high, the pin follows polarity
    wire logic tx_fsync_gen = tx_fsync_gen_select ? srg_fsync : tx_copy_fsync;
    wire logic tx_fsync_from_pin = pol_level(tx_fsync_in_s, tx_fsync_polarity);
    wire logic tx_fsync_sel = tx_fsync_source ? tx_fsync_gen : tx_fsync_from_pin;
    wire logic next_tx_fsync_int = serial_only(tx_gpio_mode, tx_fsync_sel);
    wire logic next_tx_fsync_pin_out = gpio_level(tx_gpio_mode, tx_fsync_polarity,
        pol_level(tx_fsync_gen, tx_fsync_polarity));
    wire logic next_tx_fsync_pin_oe_n = oe_n_of(tx_fsync_source);

    // transmit clock: the source bit chooses master or slave, in SPI mode too
    // as slave the far master's clock passes the pin synchroniser, so it must stay slow
    wire logic tx_clock_sel = tx_clock_source ? srg_clock : tx_clock_in_s;
    wire logic next_tx_clock_int = serial_only(tx_gpio_mode, tx_clock_sel);
    wire logic next_tx_clock_pin_out = gpio_level(tx_gpio_mode, tx_clock_polarity,
        srg_clock);
    wire logic next_tx_clock_pin_oe_n = oe_n_of(tx_clock_source);

    // receive frame sync
    wire logic rx_fsync_drive = rx_fsync_source & ~clock_sync_mode;
    wire logic rx_fsync_from_pin = pol_level(rx_fsync_in_s, rx_fsync_polarity);
    wire logic rx_fsync_sel = rx_fsync_drive ? srg_fsync : rx_fsync_from_pin;
    wire logic next_rx_fsync_int = serial_only(rx_gpio_mode, rx_fsync_sel);
    wire logic next_rx_fsync_pin_out = gpio_level(rx_gpio_mode, rx_fsync_polarity,
        pol_level(srg_fsync, rx_fsync_polarity));
    wire logic rx_fsync_pin_drive = rx_gpio_mode ? rx_fsync_source : rx_fsync_drive;
    wire logic next_rx_fsync_pin_oe_n = oe_n_of(rx_fsync_pin_drive);

    // receive clock: loopback and SPI both borrow the transmit clock; the pin drives it in loopback only
    wire logic rx_from_tx = digital_loopback | spi_mode;
    wire logic rx_clock_sel = rx_from_tx ? tx_clock_sel
        : rx_clock_source ? srg_clock : rx_clock_in_s;
    wire logic next_rx_clock_int = serial_only(rx_gpio_mode, rx_clock_sel);
    wire logic rx_clock_drive = digital_loopback ? tx_clock_sel : srg_clock;
    wire logic next_rx_clock_pin_out = gpio_level(rx_gpio_mode, rx_clock_polarity,
        rx_clock_drive);
    wire logic next_rx_clock_pin_oe_n = oe_n_of(rx_clock_source);

    // rx data crosses as a slow level: bits shorter than a few ref_clk cycles are lost
    wire logic next_rx_data_bit = serial_only(rx_gpio_mode, rx_sample_s);
    wire logic next_spi_master = spi_mode & tx_clock_source;

    // every pin and internal select is registered: one cycle from register to pin
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_data_pin_out <= 1'b0;
            tx_data_pin_oe_n <= 1'b1;
            tx_fsync_pin_out <= 1'b0;
            tx_fsync_pin_oe_n <= 1'b1;
            tx_clock_pin_out <= 1'b0;
            tx_clock_pin_oe_n <= 1'b1;
        end else begin
            tx_data_pin_out <= next_tx_data_pin_out;
            tx_data_pin_oe_n <= next_tx_data_pin_oe_n;
            tx_fsync_pin_out <= next_tx_fsync_pin_out;
            tx_fsync_pin_oe_n <= next_tx_fsync_pin_oe_n;
            tx_clock_pin_out <= next_tx_clock_pin_out;
            tx_clock_pin_oe_n <= next_tx_clock_pin_oe_n;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_fsync_pin_out <= 1'b0;
            rx_fsync_pin_oe_n <= 1'b1;
            rx_clock_pin_out <= 1'b0;
            rx_clock_pin_oe_n <= 1'b1;
        end else begin
            rx_fsync_pin_out <= next_rx_fsync_pin_out;
            rx_fsync_pin_oe_n <= next_rx_fsync_pin_oe_n;
            rx_clock_pin_out <= next_rx_clock_pin_out;
            rx_clock_pin_oe_n <= next_rx_clock_pin_oe_n;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_clock_int <= 1'b0;
            rx_clock_int <= 1'b0;
            tx_fsync_int <= 1'b0;
            rx_fsync_int <= 1'b0;
        end else begin
            tx_clock_int <= next_tx_clock_int;
            rx_clock_int <= next_rx_clock_int;
            tx_fsync_int <= next_tx_fsync_int;
            rx_fsync_int <= next_rx_fsync_int;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_data_bit <= 1'b0;
            spi_master <= 1'b0;
        end else begin
            rx_data_bit <= next_rx_data_bit;
            spi_master <= next_spi_master;
        end
    end
endmodule : spc_pin_control
`default_nettype wire

// File: spc_pin_control_properties.sv
`default_nettype none
module spc_pin_control_properties
    import spc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic tx_data_pin_out,
    input wire logic tx_data_pin_oe_n,
    input wire logic tx_fsync_pin_oe_n,
    input wire logic tx_clock_pin_oe_n,
    input wire logic rx_fsync_pin_oe_n,
    input wire logic rx_clock_pin_oe_n,
    input wire logic tx_clock_int,
    input wire logic rx_clock_int,
    input wire logic tx_fsync_int,
    input wire logic rx_fsync_int,
    input wire logic spi_master
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] serial_pin_control, sctl, pcr_q, sctl_q;
    // outputs lag the registers by one cycle, so only check once settings held still
    wire logic st = (serial_pin_control == pcr_q) && (sctl == sctl_q);
    wire logic txg = serial_pin_control[13] & ~sctl[1];
    wire logic rxg = serial_pin_control[12] & ~sctl[0];
    wire logic rd_pc = reg_rd && (reg_addr == PIN_CONTROL_ADDR);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            {serial_pin_control, sctl, pcr_q, sctl_q} <= '0;
        end else begin
            {pcr_q, sctl_q} <= {serial_pin_control, sctl};
            if (reg_wr && reg_addr == PIN_CONTROL_ADDR) serial_pin_control <= reg_wdata & PIN_CONTROL_WMASK;
            if (reg_wr && reg_addr == SERIAL_CTRL_ADDR) sctl <= reg_wdata & SERIAL_CTRL_WMASK;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    AST_RSVD_ZERO: assert property (reg_rd |=> reg_rdata[31:14] == '0 && !reg_rdata[7])
        else $error("reserved bits read nonzero");
    AST_READBACK: assert property (rd_pc |=> (reg_rdata & PIN_CONTROL_WMASK) == $past(serial_pin_control))
        else $error("pin control readback wrong");
    AST_TX_CLK_DIR: assert property (st |-> tx_clock_pin_oe_n == !serial_pin_control[9])
        else $error("tx clock pin direction wrong");
    AST_TX_FS_DIR: assert property (st && !txg |-> tx_fsync_pin_oe_n == !serial_pin_control[11])
        else $error("tx fsync pin direction wrong");
    AST_RX_FS_DIR: assert property (st && !rxg |-> rx_fsync_pin_oe_n == !(serial_pin_control[10] && !sctl[5]))
        else $error("rx fsync pin direction wrong");
    AST_RX_CLK_DIR: assert property (st |-> rx_clock_pin_oe_n == !serial_pin_control[8])
        else $error("rx clock pin direction wrong");
    AST_SPI_MASTER: assert property (st |-> spi_master == (sctl[4:3] != 2'h0 && serial_pin_control[9]))
        else $error("spi master flag wrong");
    AST_TX_GPIO: assert property (st && txg |-> !tx_data_pin_oe_n && tx_data_pin_out == serial_pin_control[5]
        && !tx_clock_int && !tx_fsync_int) else $error("tx gpio mode wrong");
    AST_RX_GPIO: assert property (st && rxg |-> !rx_clock_int && !rx_fsync_int)
        else $error("rx gpio mode wrong");
endmodule : spc_pin_control_properties
bind spc_pin_control spc_pin_control_properties i_spc_pin_control_properties (
    .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_data_pin_out, .tx_data_pin_oe_n, .tx_fsync_pin_oe_n, .tx_clock_pin_oe_n,
    .rx_fsync_pin_oe_n, .rx_clock_pin_oe_n, .tx_clock_int, .rx_clock_int,
    .tx_fsync_int, .rx_fsync_int, .spi_master
);
`default_nettype wire

// File: spc_pin_control_tb_top.sv
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module spc_pin_control_tb_top
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, link_clk, reg_wr, reg_rd, tx_data_bit, tx_data_drive;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic tx_data_pin_out, tx_data_pin_oe_n, rx_data_pin, ext_clock_in_pin;
    logic tx_clock_int, rx_clock_int, tx_fsync_int, rx_fsync_int, rx_data_bit, spi_master;
    logic [5:0] lvl;
    wire [3:0] pout, poe_n, pin;
    int err_count, checked, n;
    // row: pcr[31:16] sctl[15:8] oe_n{txfs,txclk,rxfs,rxclk}[7:4] spi[1] tx_fsync_int[0]
    localparam logic [31:0] ROWS [10] = '{32'h0000_03F1, 32'h0A00_0330, 32'h0500_03C1,
        32'h0500_23E1, 32'h0200_0BB3, 32'h0000_13F1, 32'h0100_07E1, 32'h0008_03F0,
        32'h0800_4371, 32'hFFFF_0000};
    spc_pin_control i_spc_pin_control (
        .ref_clk, .reset, .link_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .srg_clock(1'b1), .srg_fsync(1'b1), .tx_copy_fsync(1'b0), .tx_data_bit,
        .tx_data_drive, .tx_data_pin_out, .tx_data_pin_oe_n,
        .tx_fsync_pin_in(pin[3]), .tx_fsync_pin_out(pout[3]), .tx_fsync_pin_oe_n(poe_n[3]),
        .tx_clock_pin_in(pin[2]), .tx_clock_pin_out(pout[2]), .tx_clock_pin_oe_n(poe_n[2]),
        .rx_fsync_pin_in(pin[1]), .rx_fsync_pin_out(pout[1]), .rx_fsync_pin_oe_n(poe_n[1]),
        .rx_clock_pin_in(pin[0]), .rx_clock_pin_out(pout[0]), .rx_clock_pin_oe_n(poe_n[0]),
        .rx_data_pin, .ext_clock_in_pin, .tx_clock_int, .rx_clock_int, .tx_fsync_int,
        .rx_fsync_int, .rx_data_bit, .spi_master
    );
    spc_peer_model i_spc_peer_model (
        .out(pout), .oe_n(poe_n), .lvl, .pin, .rx_data_pin, .ext_clock_in_pin
    );
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : rd
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    initial begin
        {reset, reg_wr, reg_rd, tx_data_bit, tx_data_drive} = 5'b10000;
        reg_addr = '0;
        reg_wdata = '0;
        lvl = 6'h08;
        err_count = 0;
        checked = 0;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        rd(PIN_CONTROL_ADDR);
        `CHK(d & ~32'h50, 32'h0)
        `CHK(poe_n, 4'hF)
        rd(8'h10);
        `CHK(d, 32'h0)
        $display("test reset done");
        foreach (ROWS[i]) begin
            // bit 7 is always written as zero
            wr(PIN_CONTROL_ADDR, {ROWS[i][31:24], ROWS[i][23:16], ROWS[i][31:24],
                ROWS[i][23:16] & 8'h7F});
            wr(SERIAL_CTRL_ADDR, {24'h0, ROWS[i][15:8]});
            repeat (5) @(negedge ref_clk);
            `CHK(poe_n, ROWS[i][7:4])
            `CHK(spi_master, ROWS[i][1])
            `CHK(tx_fsync_int, ROWS[i][0])
            rd(PIN_CONTROL_ADDR);
            `CHK(d & ~32'h50, {16'h0, ROWS[i][31:16] & 16'h3F2F})
        end
        $display("test table done");
        wr(SERIAL_CTRL_ADDR, 32'h0);
        wr(PIN_CONTROL_ADDR, 32'h2020);
        repeat (3) @(negedge ref_clk);
        `CHK({tx_data_pin_oe_n, tx_data_pin_out}, 2'b01)
        wr(PIN_CONTROL_ADDR, 32'h2000);
        repeat (3) @(negedge ref_clk);
        `CHK({tx_data_pin_oe_n, tx_data_pin_out}, 2'b00)
        wr(PIN_CONTROL_ADDR, 32'h2020);
        tx_data_drive <= 1'b1;
        wr(SERIAL_CTRL_ADDR, 32'h2);
        repeat (4) @(negedge ref_clk);
        `CHK({tx_data_pin_oe_n, tx_data_pin_out}, 2'b00)
        $display("test tx gpio done");
        @(posedge ref_clk);
        lvl <= 6'h28;
        repeat (5) @(posedge ref_clk);
        rd(PIN_CONTROL_ADDR);
        `CHK({d[6], d[4]}, 2'b10)
        @(posedge ref_clk);
        lvl <= 6'h18;
        wr(PIN_CONTROL_ADDR, 32'h1000);
        wr(SERIAL_CTRL_ADDR, 32'h3);
        n = 0;
        while (rx_data_bit !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(rx_data_bit, 1'b1)
        wr(SERIAL_CTRL_ADDR, 32'h2);
        repeat (3) @(negedge ref_clk);
        `CHK(rx_data_bit, 1'b0)
        $display("test rx gpio done");
        wr(SERIAL_CTRL_ADDR, 32'h3);
        wr(PIN_CONTROL_ADDR, 32'h0700);
        repeat (5) @(negedge ref_clk);
        `CHK({tx_clock_int, rx_clock_int, rx_fsync_int}, 3'b111)
        `CHK(pout[2:0], 3'b111)
        `CHK(poe_n, 4'h8)
        wr(PIN_CONTROL_ADDR, 32'h0000);
        repeat (5) @(negedge ref_clk);
        `CHK({tx_clock_int, rx_clock_int, rx_fsync_int}, 3'b000)
        $display("test clock select done");
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(PIN_CONTROL_ADDR);
        `CHK(d & ~32'h50, 32'h0)
        `CHK(poe_n, 4'hF)
        `CHK({tx_clock_int, rx_clock_int, spi_master}, 3'b000)
        $display("test mid reset done");
        test_done();
    end
endmodule : spc_pin_control_tb_top
`default_nettype wire

// File: spc_pkg.sv
`default_nettype none
package spc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] PIN_CONTROL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] SERIAL_CTRL_ADDR = 8'h04;

    // serial_pin_control field positions
    localparam int TX_GPIO_ENABLE_BIT = 13;
    localparam int RX_GPIO_ENABLE_BIT = 12;
    localparam int TX_FSYNC_SOURCE_BIT = 11;
    localparam int RX_FSYNC_SOURCE_BIT = 10;
    localparam int TX_CLOCK_SOURCE_BIT = 9;
    localparam int RX_CLOCK_SOURCE_BIT = 8;
    localparam int EXT_CLOCK_LEVEL_BIT = 6;
    localparam int TX_DATA_LEVEL_BIT = 5;
    localparam int RX_DATA_LEVEL_BIT = 4;
    localparam int TX_FSYNC_POL_BIT = 3;
    localparam int RX_FSYNC_POL_BIT = 2;
    localparam int TX_CLOCK_POL_BIT = 1;
    localparam int RX_CLOCK_POL_BIT = 0;
    localparam logic [DATA_W-1:0] PIN_CONTROL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PIN_CONTROL_WMASK = 32'h0000_3F2F;

    // serial_ctrl field positions
    localparam int RX_SECTION_RESET_N_BIT = 0;
    localparam int TX_SECTION_RESET_N_BIT = 1;
    localparam int DIGITAL_LOOPBACK_BIT = 2;
    localparam int CLOCK_STOP_MODE_LO = 3;
    localparam int CLOCK_STOP_MODE_HI = 4;
    localparam int CLOCK_SYNC_MODE_BIT = 5;
    localparam int TX_FSYNC_GEN_SELECT_BIT = 6;
    localparam logic [DATA_W-1:0] SERIAL_CTRL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SERIAL_CTRL_WMASK = 32'h0000_007F;
endpackage : spc_pkg
`default_nettype wire

// File: spc_rx_sample.sv
`default_nettype none
module spc_rx_sample
    import spc_pkg::*;
(
    input wire logic link_clk,
    input wire logic reset,
    input wire logic rx_data_pin,
    input wire logic rx_clock_polarity,
    output logic rx_sample
);
    logic rise_bit;
    logic fall_bit;
    logic pol_link;
    wire logic next_rx_sample;

    // polarity is a ref_clk register: it crosses as a slow level
    spc_sync #(.WIDTH(1)) u_pol_sync (
        .clk(link_clk),
        .reset(reset),
        .d(rx_clock_polarity),
        .q(pol_link)
    );

    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            rise_bit <= 1'b0;
        end else begin
            rise_bit <= rx_data_pin;
        end
    end

    always_ff @(negedge link_clk or posedge reset) begin
        if (reset) begin
            fall_bit <= 1'b0;
        end else begin
            fall_bit <= rx_data_pin;
        end
    end

    assign next_rx_sample = pol_link ? rise_bit : fall_bit;

    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            rx_sample <= 1'b0;
        end else begin
            rx_sample <= next_rx_sample;
        end
    end
endmodule : spc_rx_sample
`default_nettype wire

// File: spc_sync.sv
`default_nettype none
module spc_sync
    import spc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only q, to keep metastability out of the logic
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule : spc_sync
`default_nettype wire
